//--- rtl/rsq_pkg.sv
// constants and types shared by the reset sequencer and its delay counter
package rsq_pkg;

  // register bus
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ICS_ADDR     = 12'h000;
  localparam logic [7:0]  ICS_RESET    = 8'h60;
  localparam logic [1:0]  TRIM_RESET   = 2'h3;

  // integrity_ctrl_status field positions
  localparam int B_FAST_LOCK = 7;
  localparam int B_TRIM_HI   = 6;
  localparam int B_TRIM_LO   = 5;
  localparam int B_WDG       = 4;
  localparam int B_LOCK      = 3;
  localparam int B_LOW_SUPPLY_RESET_FLAG     = 2;
  localparam int B_SUPPLY_WARN_FLAG      = 1;
  localparam int B_SUPPLY_WARN_IRQ_ENABLE     = 0;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CNT_W          = 13;
  localparam logic [12:0] DELAY_SHORT = 13'h0100;
  localparam logic [12:0] DELAY_LONG  = 13'h1000;
  localparam int WDG_PULSE_NS   = 500;
  localparam int PLL_STARTUP_NS = 1000;
  localparam logic [7:0] WDG_PULSE_CYC =
    8'((WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PLL_STARTUP_CYC =
    8'((PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CNT8_ONE = 8'h01;

  // reset vector
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFF;

  // clock source option codes
  localparam logic [1:0] CLK_SRC_RC   = 2'h0;
  localparam logic [1:0] CLK_SRC_EXT  = 2'h1;
  localparam logic [1:0] CLK_SRC_XTAL = 2'h2;

  // option settings as one carrier
  typedef struct packed {
    logic       pll_en;
    logic [1:0] clk_src;
    logic [1:0] lvd_level;
    logic       lvd_en;
  } opt_t;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_DELAY  = 5'h02,
    ST_PLL    = 5'h04,
    ST_FETCH  = 5'h08,
    ST_RUN    = 5'h10
  } seq_state_t;

endpackage

//--- rtl/startup_counter.sv
// counts the start-up delay phase in cpu clock cycles
`timescale 1ns/1ns
`default_nettype none
module startup_counter (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  input  wire logic long_sel,
  // status
  output logic      done
);
  import rsq_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] target;

  assign target = long_sel ? DELAY_LONG : DELAY_SHORT;

  // dropping run restarts from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (!done) begin
      count <= count + CNT_W'(1);
    end
  end

  assign done = run && (count == target - CNT_W'(1));

endmodule
`default_nettype wire

//--- rtl/reset_sequencer_supply_monitor.sv
// reset sequencer and supply integrity logic with apb register access
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module reset_sequencer_supply_monitor (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [rsq_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // reset pin, open drain
  input  wire logic                RST_PIN_IN,
  output logic                     RST_PIN_OUT,
  output logic                     RST_PIN_OE_N,
  // reset sources
  input  wire logic                WDG_UNDERFLOW,
  input  wire logic                ILLEGAL_OP,
  // analog and pll status
  input  wire logic                LVD_BELOW,
  input  wire logic                AVD_BELOW,
  input  wire logic                PLL_LOCK,
  input  wire logic                PLL32_LOCK,
  // option settings
  input  wire rsq_pkg::opt_t       OPTIONS,
  // core side
  input  wire logic                CPU_I_MASK,
  input  wire logic                CPU_WAIT,
  input  wire logic                CPU_HALT,
  input  wire logic                IRQ_ACK,
  output logic                     SUPPLY_IRQ,
  output logic                     WAKE_REQ,
  output logic                     CORE_RESET_N,
  output logic                     CORE_CLK_EN,
  output logic                     VEC_FETCH,
  output logic [15:0]              VEC_ADDR,
  // detector and oscillator controls
  output logic                     LVD_ENABLE,
  output logic [1:0]               LVD_THRESHOLD,
  output logic [1:0]               OSC_TRIM
);
  import rsq_pkg::*;

  seq_state_t state;
  seq_state_t next_state;
  opt_t       opt_s1;
  opt_t       opt_s2;
  logic [3:0] ana_s1;
  logic [3:0] ana_s2;
  logic       ext_arm_n;
  logic       ext_seen;
  logic       ext_s1;
  logic       ext_s2;
  logic       lvd_low;
  logic       lvd_q;
  logic       lvd_evt;
  logic       supply_warn_flag;
  logic       supply_warn_flag_q;
  logic [7:0] pulse_cnt;
  logic       src_active;
  logic       dly_done;
  logic [7:0] pll_cnt;
  logic       fetch_cnt;
  logic       wdg_flag;
  logic       low_supply_reset_flag;
  logic [1:0] trim;
  logic       supply_warn_irq_enable;
  logic       pending;
  logic [7:0] reg_val;
  logic       addr_hit;
  logic       wr_acc;
  logic       rd_acc;

  // opts and analog levels come from outside the clock domain
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      opt_s1 <= '0;
      opt_s2 <= '0;
      ana_s1 <= '0;
      ana_s2 <= '0;
    end else begin
      opt_s1 <= OPTIONS;
      opt_s2 <= opt_s1;
      ana_s1 <= {PLL32_LOCK, PLL_LOCK, AVD_BELOW, LVD_BELOW};
      ana_s2 <= ana_s1;
    end
  end

  // our own drive reads back low, so it must not look external
  assign ext_arm_n = RST_PIN_IN | ~RST_PIN_OE_N;

  // caught asynchronously so a stopped clock cannot miss it
  always_ff @(posedge CLK or negedge ext_arm_n or negedge RST_N) begin
    if (!RST_N) begin
      ext_seen <= 1'b0;
    end else if (!ext_arm_n) begin
      ext_seen <= 1'b1;
    end else begin
      ext_seen <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      ext_s1 <= ext_seen;
      ext_s2 <= ext_s1;
    end
  end

  assign lvd_low = opt_s2.lvd_en & ana_s2[0];
  assign supply_warn_flag    = opt_s2.lvd_en & ana_s2[1];
  assign lvd_evt = lvd_low & ~lvd_q;
  assign LVD_ENABLE    = opt_s2.lvd_en;
  assign LVD_THRESHOLD = opt_s2.lvd_level;

  // internal sources stretched to the minimum pin pulse
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pulse_cnt <= '0;
    end else if (WDG_UNDERFLOW || ILLEGAL_OP) begin
      pulse_cnt <= WDG_PULSE_CYC;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - CNT8_ONE;
    end
  end

  assign src_active = ext_s2 | lvd_low | WDG_UNDERFLOW | ILLEGAL_OP
                    | (pulse_cnt != '0);

  startup_counter delay_cnt (
    .clk      (CLK),
    .rst_n    (RST_N),
    .run      (state == ST_DELAY),
    .long_sel (opt_s2.clk_src == CLK_SRC_XTAL),
    .done     (dly_done)
  );

  // sequencer; any source pulls back to the active phase
  always_comb begin
    next_state = state;
    if (src_active) begin
      next_state = ST_ACTIVE;
    end else begin
      case (state)
        ST_ACTIVE: next_state = ST_DELAY;
        ST_DELAY: begin
          if (dly_done) begin
            next_state = opt_s2.pll_en ? ST_PLL : ST_FETCH;
          end
        end
        ST_PLL: begin
          if (pll_cnt == PLL_STARTUP_CYC - CNT8_ONE) begin
            next_state = ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (fetch_cnt) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN:   next_state = ST_RUN;
        default:  next_state = ST_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pll_cnt   <= '0;
      fetch_cnt <= 1'b0;
    end else begin
      pll_cnt   <= (state == ST_PLL) ? pll_cnt + CNT8_ONE : '0;
      fetch_cnt <= (state == ST_FETCH) && !fetch_cnt;
    end
  end

  // pin, core reset, clock gate and vector fetch
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RST_PIN_OE_N <= 1'b0;
      CORE_RESET_N <= 1'b0;
      CORE_CLK_EN  <= 1'b1;
      VEC_FETCH    <= 1'b0;
      VEC_ADDR     <= VEC_ADDR_LO;
    end else begin
      RST_PIN_OE_N <= (next_state == ST_FETCH) || (next_state == ST_RUN);
      CORE_RESET_N <= (next_state == ST_RUN);
      CORE_CLK_EN  <= (next_state != ST_PLL);
      VEC_FETCH    <= (next_state == ST_FETCH);
      VEC_ADDR     <= (next_state == ST_FETCH && state == ST_FETCH)
                      ? VEC_ADDR_HI : VEC_ADDR_LO;
    end
  end

  assign RST_PIN_OUT = 1'b0;

  // apb: zero wait states, unmapped addresses answer with error
  assign addr_hit = (PADDR == ICS_ADDR);
  assign wr_acc   = PSEL & PENABLE & PWRITE & addr_hit & ~CPU_HALT;
  assign rd_acc   = PSEL & PENABLE & ~PWRITE & addr_hit & ~CPU_HALT;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL & PENABLE & ~addr_hit;

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdg_flag <= ICS_RESET[B_WDG];
    end else if (WDG_UNDERFLOW) begin
      wdg_flag <= 1'b1;
    end else if (lvd_evt || (wr_acc && !PWDATA[B_WDG])) begin
      wdg_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_supply_reset_flag <= ICS_RESET[B_LOW_SUPPLY_RESET_FLAG];
      lvd_q <= 1'b0;
    end else begin
      lvd_q <= lvd_low;
      if (lvd_evt) begin
        low_supply_reset_flag <= 1'b1;
      end else if (rd_acc) begin
        low_supply_reset_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trim  <= TRIM_RESET;
      supply_warn_irq_enable <= ICS_RESET[B_SUPPLY_WARN_IRQ_ENABLE];
    end else if (wr_acc) begin
      trim  <= PWDATA[B_TRIM_HI:B_TRIM_LO];
      supply_warn_irq_enable <= PWDATA[B_SUPPLY_WARN_IRQ_ENABLE];
    end
  end

  assign OSC_TRIM = trim;

  // pending latches even while masked; no new events in halt
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      supply_warn_flag_q  <= 1'b0;
      pending <= 1'b0;
    end else begin
      supply_warn_flag_q <= supply_warn_flag;
      if (supply_warn_flag && !supply_warn_flag_q && !CPU_HALT) begin
        pending <= 1'b1;
      end else if (IRQ_ACK) begin
        pending <= 1'b0;
      end
    end
  end

  assign SUPPLY_IRQ = pending & supply_warn_irq_enable & ~CPU_I_MASK;
  assign WAKE_REQ   = SUPPLY_IRQ & CPU_WAIT & ~CPU_HALT;

  // lock and warn bits are live, software cannot write them
  assign reg_val = {ana_s2[3], trim, wdg_flag, ana_s2[2],
                    low_supply_reset_flag, supply_warn_flag, supply_warn_irq_enable};

  // read data captured in the setup cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= addr_hit ? {24'h00_0000, reg_val} : '0;
    end
  end

  // helper for delay length check
  logic [CNT_W-1:0] dly_seen;
  logic [CNT_W-1:0] dly_target;
  assign dly_target = (opt_s2.clk_src == CLK_SRC_XTAL) ? DELAY_LONG : DELAY_SHORT;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly_seen <= '0;
    end else begin
      dly_seen <= (state == ST_DELAY) ? dly_seen + CNT_W'(1) : '0;
    end
  end

  pin_in_delay_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (state == ST_DELAY || state == ST_ACTIVE) |-> !RST_PIN_OE_N)
    else $error("reset pin released before fetch");

  delay_len_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (state == ST_DELAY && !src_active && dly_done) |-> dly_seen == dly_target - CNT_W'(1))
    else $error("delay phase length wrong");

  fetch_two_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ($rose(VEC_FETCH) && !src_active) |=> (VEC_FETCH && VEC_ADDR == VEC_ADDR_HI) ##1 !VEC_FETCH)
    else $error("vector fetch not two cycles");

  vector_lo_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $rose(VEC_FETCH) |-> VEC_ADDR == VEC_ADDR_LO)
    else $error("vector fetch does not start at low byte");

  release_fetch_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $rose(RST_PIN_OE_N) |-> $rose(VEC_FETCH) && state == ST_FETCH)
    else $error("pin released outside fetch start");

  restart_delay_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (state == ST_DELAY && src_active) |=> state == ST_ACTIVE ##1 dly_seen == '0)
    else $error("delay not restarted");

  wdg_pulse_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    WDG_UNDERFLOW |=> !RST_PIN_OE_N [*8])
    else $error("watchdog pin pulse too short");

  wdg_flag_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    WDG_UNDERFLOW |=> wdg_flag)
    else $error("watchdog flag not set");

  low_supply_reset_flag_set_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    lvd_evt |=> low_supply_reset_flag && !wdg_flag)
    else $error("low supply flag update wrong");

  irq_gate_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    SUPPLY_IRQ |-> pending && supply_warn_irq_enable && !CPU_I_MASK)
    else $error("irq raised without enable");

  aux_idle_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !opt_s2.lvd_en |-> !supply_warn_flag ##1 !$rose(pending))
    else $error("aux detector active while disabled");

  halt_freeze_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (CPU_HALT && $past(CPU_HALT)) |-> $stable(trim) && $stable(supply_warn_irq_enable) && !WAKE_REQ)
    else $error("register changed in halt");

endmodule
`default_nettype wire

//--- sim/ext_reset_board.sv
// board side of the reset pin: external pull-down and weak pull-up
`timescale 1ns/1ns
`default_nettype none
module ext_reset_board (
  // drivers of the pin
  input  wire logic pull_low,
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // resolved level
  output logic      pin
);
  // open drain: the weak pull-up wins only when nobody sinks current
  assign pin = (pull_low || (!dev_oe_n && !dev_out)) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

//--- sim/tb_reset_sequencer_supply_monitor.sv
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/1ns
`default_nettype none
module tb_reset_sequencer_supply_monitor;
  import rsq_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pin, pin_out, oe_n, ext_low, wdg, ill, low_supply_detector, aux_supply_detector, pll, pll32;
  logic        imask, cwait, chalt, ack, irq, wake, core_rst_n, clk_en, vfetch, lvd_on;
  logic [15:0] vaddr;
  logic [1:0]  thr, trim;
  logic [7:0]  rd;
  opt_t        opt;
  int          n_errors, checks;

  reset_sequencer_supply_monitor dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RST_PIN_IN(pin), .RST_PIN_OUT(pin_out), .RST_PIN_OE_N(oe_n), .WDG_UNDERFLOW(wdg),
    .ILLEGAL_OP(ill), .LVD_BELOW(low_supply_detector), .AVD_BELOW(aux_supply_detector), .PLL_LOCK(pll), .PLL32_LOCK(pll32),
    .OPTIONS(opt), .CPU_I_MASK(imask), .CPU_WAIT(cwait), .CPU_HALT(chalt), .IRQ_ACK(ack),
    .SUPPLY_IRQ(irq), .WAKE_REQ(wake), .CORE_RESET_N(core_rst_n), .CORE_CLK_EN(clk_en),
    .VEC_FETCH(vfetch), .VEC_ADDR(vaddr), .LVD_ENABLE(lvd_on), .LVD_THRESHOLD(thr),
    .OSC_TRIM(trim));
  ext_reset_board board (.pull_low(ext_low), .dev_out(pin_out), .dev_oe_n(oe_n), .pin(pin));

  initial begin
    clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  // t: 0 pin, 1 watchdog, 2 illegal opcode, 3 low supply; re: second watchdog pulse
  task automatic run_seq(input int t, input int re);
    int i, n_low, n_fetch, n_off, base;
    n_low = 0;
    n_fetch = 0;
    n_off = 0;
    for (i = 0; i < 8 || core_rst_n !== 1'h1; i++) begin
      ext_low <= (t == 0 && i < 20);
      low_supply_detector <= (t == 3 && i < 20);
      wdg <= (t == 1 && (i == 0 || (re > 0 && i == re)));
      ill <= (t == 2 && i == 0);
      @(posedge clk);
      if (oe_n === 1'h0) n_low++;
      if (clk_en === 1'h0) n_off++;
      if (vfetch === 1'h1) begin
        chk("vector", vaddr, n_fetch ? VEC_ADDR_HI : VEC_ADDR_LO);
        chk("pin free", oe_n, 1);
        n_fetch++;
      end else if (oe_n === 1'h0) begin
        chk("pin low", pin, 0);
      end
    end
    // own pin drive masks the external pulse, so only its sync latency counts
    base = re + ((t == 1 || t == 2) ? int'(WDG_PULSE_CYC) : (t == 0) ? 3 : 20);
    base += (opt.clk_src === CLK_SRC_XTAL) ? int'(DELAY_LONG) : int'(DELAY_SHORT);
    base += opt.pll_en ? int'(PLL_STARTUP_CYC) : 0;
    chk("low span", n_low >= base - 4 && n_low <= base + 8, 1);
    chk("fetch len", n_fetch, 2);
    chk("pll hold", n_off, opt.pll_en ? PLL_STARTUP_CYC : 8'h00);
  endtask

  task automatic t_regs();
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("reset value", rd, ICS_RESET);
    pll <= 1'h1;
    pll32 <= 1'h1;
    tick(4);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("locks", rd, 8'hE8);
    apb(1'h1, ICS_ADDR, 8'hFF);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("write mask", rd, 8'hE9);
    apb(1'h1, ICS_ADDR, 8'h00);
    chk("trim out", trim, 0);
    apb(1'h0, 12'h004, 8'h00);
    chk("unmapped", {err, rd}, 9'h100);
    chk("lvd opts", {lvd_on, thr}, {opt.lvd_en, opt.lvd_level});
  endtask

  task automatic t_sources();
    for (int t = 0; t < 3; t++) run_seq(t, 0);
    chalt <= 1'h1;
    run_seq(0, 0);
    chalt <= 1'h0;
  endtask

  task automatic t_clocks();
    opt.clk_src <= CLK_SRC_EXT;
    tick(4);
    run_seq(1, 0);
    opt.clk_src <= CLK_SRC_XTAL;
    tick(4);
    run_seq(2, 0);
    opt.clk_src <= CLK_SRC_RC;
    opt.pll_en <= 1'h1;
    tick(4);
    run_seq(1, 0);
    opt.pll_en <= 1'h0;
    tick(4);
    run_seq(1, 200);
  endtask

  task automatic t_flags();
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("wdg set", rd[4], 1);
    apb(1'h1, ICS_ADDR, 8'h00);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("wdg clear", rd[4], 0);
    run_seq(1, 0);
    opt.lvd_en <= 1'h1;
    tick(4);
    run_seq(3, 0);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("low set", {rd[4], rd[2]}, 2'h1);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("low read", rd[2], 0);
    run_seq(3, 0);
    run_seq(0, 0);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("low kept", rd[2], 1);
  endtask

  task automatic pulse_ack();
    ack <= 1'h1;
    tick(1);
    ack <= 1'h0;
    tick(1);
  endtask

  task automatic t_irq();
    apb(1'h1, ICS_ADDR, 8'h01);
    aux_supply_detector <= 1'h1;
    tick(4);
    chk("irq", irq, 1);
    apb(1'h1, ICS_ADDR, 8'h01);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("warn live", rd[1], 1);
    cwait <= 1'h1;
    tick(1);
    chk("wake", wake, 1);
    pulse_ack();
    chk("ack", irq, 0);
    aux_supply_detector <= 1'h0;
    imask <= 1'h1;
    tick(4);
    aux_supply_detector <= 1'h1;
    tick(4);
    chk("masked", irq, 0);
    imask <= 1'h0;
    tick(1);
    chk("unmasked", irq, 1);
    pulse_ack();
    aux_supply_detector <= 1'h0;
    chalt <= 1'h1;
    tick(4);
    aux_supply_detector <= 1'h1;
    tick(4);
    chk("halt", {irq, wake}, 0);
    apb(1'h1, ICS_ADDR, 8'h60);
    chalt <= 1'h0;
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("frozen", {rd[6:5], rd[0]}, 3'h1);
    opt.lvd_en <= 1'h0;
    tick(4);
    apb(1'h0, ICS_ADDR, 8'h00);
    chk("aux off", rd[1], 0);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, ext_low, wdg, ill, low_supply_detector, aux_supply_detector, pll, pll32} = 11'h000;
    {imask, cwait, chalt, ack} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    opt = '{1'h0, CLK_SRC_RC, 2'h1, 1'h0};
    n_errors = 0;
    checks = 0;
    tick(16);
    rst_n <= 1'h1;
    while (core_rst_n !== 1'h1) @(posedge clk);
    t_regs();
    t_sources();
    t_clocks();
    t_flags();
    t_irq();
    end_of_test();
  end

  // hang guard, well above the longest expected run
  initial begin
    tick(30000);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
